// ==== core/fopw_pkg.sv ====
// Constants, types and reset image for the flash and OTP power and wait control
package fopw_pkg;
	localparam int ADDR_W     = 22;
	localparam int ROW_LOG2   = 7;
	localparam int ROW_W      = ADDR_W - ROW_LOG2;
	localparam int OTP_WORDS  = 1024;
	localparam int REG_AW     = 16;

	localparam logic [REG_AW-1:0] REG_POWER  = 16'h0A82;
	localparam logic [REG_AW-1:0] REG_STATUS = 16'h0A83;
	localparam logic [REG_AW-1:0] REG_STDBY  = 16'h0A84;
	localparam logic [REG_AW-1:0] REG_ACTIVE = 16'h0A85;
	localparam logic [REG_AW-1:0] REG_BANK   = 16'h0A86;
	localparam logic [REG_AW-1:0] REG_OTP    = 16'h0A87;

	localparam int PWR_LSB    = 0;
	localparam int RAND_LSB   = 0;
	localparam int PAGE_LSB   = 8;
	localparam int OTPW_LSB   = 0;
	localparam int STAT_PWR   = 0;
	localparam int STAT_RUN   = 2;
	localparam int STAT_BUSY  = 3;

	localparam logic [15:0] STDBY_RST  = 16'h01FF;
	localparam logic [15:0] ACTIVE_RST = 16'h01FF;
	localparam logic [3:0]  RAND_RST   = 4'hF;
	localparam logic [3:0]  PAGE_RST   = 4'hF;
	localparam logic [4:0]  OTPW_RST   = 5'h1F;

	typedef enum logic [1:0] {
		FOPW_SLEEP   = 2'b00,
		FOPW_STANDBY = 2'b01,
		FOPW_ACTIVE  = 2'b11
	} fopw_pwr_e;

	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_POWER = 2'b01,
		ACC_WAIT  = 2'b10
	} fopw_acc_e;

	typedef enum logic [1:0] {
		KIND_FETCH32 = 2'b00,
		KIND_DATA16  = 2'b01,
		KIND_DATA32  = 2'b10,
		KIND_PROG16  = 2'b11
	} fopw_kind_e;

	typedef struct packed {
		logic              valid;
		logic              we;
		fopw_kind_e        kind;
		logic [ADDR_W-1:0] addr;
	} fopw_cpu_req_s;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [REG_AW-1:0] addr;
		logic [15:0]       wdata;
	} fopw_reg_req_s;

	typedef struct packed {
		fopw_pwr_e         cur_pwr;
		fopw_pwr_e         tgt_pwr;
		logic              pcnt_run;
		logic [15:0]       pcnt;
		fopw_acc_e         acc;
		logic [4:0]        wcnt;
		logic [ADDR_W-1:0] addr;
		fopw_kind_e        kind;
		logic              row_vld;
		logic [ROW_W-1:0]  open_row;
		logic [15:0]       stdby_wait;
		logic [15:0]       active_wait;
		logic [3:0]        rand_w;
		logic [3:0]        page_w;
		logic [4:0]        otp_w;
		logic              ack;
		logic [31:0]       rdata;
		logic [15:0]       reg_rdata;
	} fopw_state_s;

	localparam fopw_state_s STATE_RST = '{
		cur_pwr:     FOPW_SLEEP,
		tgt_pwr:     FOPW_SLEEP,
		pcnt_run:    1'b0,
		pcnt:        16'h0000,
		acc:         ACC_IDLE,
		wcnt:        5'h00,
		addr:        22'h000000,
		kind:        KIND_FETCH32,
		row_vld:     1'b0,
		open_row:    15'h0000,
		stdby_wait:  STDBY_RST,
		active_wait: ACTIVE_RST,
		rand_w:      RAND_RST,
		page_w:      PAGE_RST,
		otp_w:       OTPW_RST,
		ack:         1'b0,
		rdata:       32'h00000000,
		reg_rdata:   16'h0000
	};
endpackage

// ==== core/fopw_core.sv ====
// Flash and OTP power state, wake-up delay and wait-state control
// What this block does
// - Reset puts bank and pump to sleep
// - Access in sleep wakes through standby, stalling CPU
// - Access in standby wakes to active, stalling CPU
// - Bank and pump share one power state
// - Software lower power write takes effect immediately
// - Software higher power write rises after delay
// - Access during rising delay stalls until done
// - Standby and active waits time each step
// - Active accesses use bank or OTP waits
// - Accept fetch32, data16/32, program16 reads
// - Rows of 2048 bits; first access random
// - Same row follow-on accesses are paged
// - Random and page wait fields set waits
// - Bank waits reset to worst case
// - Page wait zero gives zero-wait paged access
// - 1K x 16 OTP in both spaces
// - OTP timed by OTP waits, never paged
// - Writes to memory ignored, done in one cycle
`timescale 1ns/1ns
`default_nettype none

module fopw_core
	import fopw_pkg::*;
#(
	parameter logic [ADDR_W-1:0] FLASH_BASE  = 22'h010000,
	parameter logic [ADDR_W:0]   FLASH_WORDS = 23'h010000,
	parameter logic [ADDR_W-1:0] OTP_BASE    = 22'h008000
) (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire fopw_cpu_req_s cpu_req,
	output logic               cpu_stall,
	output logic               cpu_ack,
	output logic [31:0]        cpu_rdata,
	output logic               mem_rd,
	output logic [ADDR_W-1:0]  mem_addr,
	input  wire logic [31:0]   mem_rdata,
	input  wire fopw_reg_req_s reg_req,
	output logic [15:0]        reg_rdata,
	output fopw_pwr_e          bank_pwr,
	output fopw_pwr_e          pump_pwr
);
	localparam logic [ADDR_W:0] FLASH_END = {1'b0, FLASH_BASE} + FLASH_WORDS;
	localparam logic [ADDR_W:0] OTP_END   = {1'b0, OTP_BASE} + (ADDR_W+1)'(OTP_WORDS);

	fopw_state_s       s;
	fopw_state_s       next_s;
	logic              req_flash;
	logic              req_otp;
	logic              req_hit;
	logic              go_flash;
	logic              go_otp;
	logic [ADDR_W-1:0] go_addr;
	fopw_kind_e        go_kind;
	logic [ROW_W-1:0]  go_row;
	logic              mem_ready;
	logic              go;
	logic [4:0]        waits;
	fopw_pwr_e         wr_pwr;

	// Address decode of the incoming request
	assign req_flash = ({1'b0, cpu_req.addr} >= {1'b0, FLASH_BASE})
		&& ({1'b0, cpu_req.addr} < FLASH_END);
	assign req_otp   = ({1'b0, cpu_req.addr} >= {1'b0, OTP_BASE})
		&& ({1'b0, cpu_req.addr} < OTP_END);
	assign req_hit   = cpu_req.valid && (req_flash || req_otp);

	// Access being resolved: new request when idle, held one otherwise
	assign go_addr   = (s.acc == ACC_IDLE) ? cpu_req.addr : s.addr;
	assign go_kind   = (s.acc == ACC_IDLE) ? cpu_req.kind : s.kind;
	assign go_otp    = ({1'b0, go_addr} >= {1'b0, OTP_BASE})
		&& ({1'b0, go_addr} < OTP_END);
	assign go_flash  = !go_otp;
	assign go_row    = go_addr[ADDR_W-1:ROW_LOG2];
	assign mem_ready = (s.cur_pwr == FOPW_ACTIVE) && !s.pcnt_run;
	assign go        = mem_ready && ((s.acc == ACC_POWER)
		|| ((s.acc == ACC_IDLE) && req_hit && !cpu_req.we));

	// Wait-state selection
	always_comb begin
		if (go_otp) begin
			waits = s.otp_w;
		end else if (s.row_vld && (go_row == s.open_row)) begin
			waits = {1'b0, s.page_w};
		end else begin
			waits = {1'b0, s.rand_w};
		end
	end

	// Power field decode; the unused code counts as standby
	always_comb begin
		unique case (reg_req.wdata[PWR_LSB +: 2])
			2'b00: wr_pwr = FOPW_SLEEP;
			2'b11: wr_pwr = FOPW_ACTIVE;
			default: wr_pwr = FOPW_STANDBY;
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.reg_rdata = 16'h0000;

		// Power engine: one step at a time, each timed by its register
		if (s.pcnt_run) begin
			if (s.pcnt <= 16'h0001) begin
				if (s.cur_pwr == FOPW_SLEEP) begin
					next_s.cur_pwr = FOPW_STANDBY;
					if (s.tgt_pwr == FOPW_ACTIVE) begin
						next_s.pcnt = s.active_wait;
					end else begin
						next_s.pcnt_run = 1'b0;
					end
				end else begin
					next_s.cur_pwr = FOPW_ACTIVE;
					next_s.pcnt_run = 1'b0;
				end
			end else begin
				next_s.pcnt = s.pcnt - 16'h0001;
			end
		end else if (s.tgt_pwr > s.cur_pwr) begin
			next_s.pcnt_run = 1'b1;
			if (s.cur_pwr == FOPW_SLEEP) begin
				next_s.pcnt = s.stdby_wait;
			end else begin
				next_s.pcnt = s.active_wait;
			end
		end

		// Register writes
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				REG_POWER: begin
					next_s.tgt_pwr = wr_pwr;
					if (wr_pwr <= s.cur_pwr) begin
						next_s.cur_pwr = wr_pwr;
						next_s.pcnt_run = 1'b0;
						next_s.row_vld = 1'b0;
					end
				end
				REG_STDBY: next_s.stdby_wait = reg_req.wdata;
				REG_ACTIVE: next_s.active_wait = reg_req.wdata;
				REG_BANK: begin
					next_s.rand_w = reg_req.wdata[RAND_LSB +: 4];
					next_s.page_w = reg_req.wdata[PAGE_LSB +: 4];
				end
				REG_OTP: next_s.otp_w = reg_req.wdata[OTPW_LSB +: 5];
				default: ;
			endcase
		end

		// Register reads, data in the following cycle only
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				REG_POWER: next_s.reg_rdata = {14'h0000, s.tgt_pwr};
				REG_STATUS: next_s.reg_rdata = {12'h000, (s.acc != ACC_IDLE),
					s.pcnt_run, s.cur_pwr};
				REG_STDBY: next_s.reg_rdata = s.stdby_wait;
				REG_ACTIVE: next_s.reg_rdata = s.active_wait;
				REG_BANK: next_s.reg_rdata = {4'h0, s.page_w, 4'h0, s.rand_w};
				REG_OTP: next_s.reg_rdata = {11'h000, s.otp_w};
				default: next_s.reg_rdata = 16'h0000;
			endcase
		end

		// CPU access sequencing
		unique case (s.acc)
			ACC_IDLE: begin
				if (req_hit && cpu_req.we) begin
					next_s.ack = 1'b1;
				end else if (req_hit && !go) begin
					next_s.acc = ACC_POWER;
					next_s.addr = cpu_req.addr;
					next_s.kind = cpu_req.kind;
				end
			end
			ACC_POWER: begin
				if (!go) begin
					next_s.tgt_pwr = FOPW_ACTIVE;
				end
			end
			ACC_WAIT: begin
				if (s.wcnt <= 5'h01) begin
					next_s.ack = 1'b1;
					next_s.acc = ACC_IDLE;
					if ((s.kind == KIND_FETCH32) || (s.kind == KIND_DATA32)) begin
						next_s.rdata = mem_rdata;
					end else begin
						next_s.rdata = {16'h0000, mem_rdata[15:0]};
					end
				end else begin
					next_s.wcnt = s.wcnt - 5'h01;
				end
			end
			default: next_s.acc = ACC_IDLE;
		endcase

		// Request while the memory is not active or still rising raises the target at once
		if ((s.acc == ACC_IDLE) && req_hit && !cpu_req.we && !go) begin
			next_s.tgt_pwr = FOPW_ACTIVE;
		end

		// Resolve an access once the memory is active
		if (go) begin
			next_s.addr = go_addr;
			next_s.kind = go_kind;
			if (go_flash) begin
				next_s.row_vld = 1'b1;
				next_s.open_row = go_row;
			end
			if (waits == 5'h00) begin
				next_s.ack = 1'b1;
				next_s.acc = ACC_IDLE;
				if ((go_kind == KIND_FETCH32) || (go_kind == KIND_DATA32)) begin
					next_s.rdata = mem_rdata;
				end else begin
					next_s.rdata = {16'h0000, mem_rdata[15:0]};
				end
			end else begin
				next_s.wcnt = waits;
				next_s.acc = ACC_WAIT;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign cpu_stall = (s.acc != ACC_IDLE);
	assign cpu_ack   = s.ack;
	assign cpu_rdata = s.rdata;
	assign mem_rd    = go || (s.acc == ACC_WAIT);
	assign mem_addr  = go_addr;
	assign reg_rdata = s.reg_rdata;
	assign bank_pwr  = s.cur_pwr;
	assign pump_pwr  = s.cur_pwr;
endmodule

`default_nettype wire

// ==== tb/fopw_mem_model.sv ====
// Flash array stand-in answering reads from the address
`timescale 1ns/1ns
`default_nettype none
module fopw_mem_model (
	input  wire logic        rd,
	input  wire logic [21:0] addr,
	output logic [31:0]      data
);
	// Idle array shows the inverse pattern
	assign data = rd ? {10'h3C5, addr} : ~{10'h3C5, addr};
endmodule
`default_nettype wire

// ==== tb/fopw_assertions.sv ====
// Port assertions for the flash and OTP power and wait control
`timescale 1ns/1ns
`default_nettype none
module fopw_assertions
	import fopw_pkg::*;
#(
	parameter logic [ADDR_W-1:0] FLASH_BASE  = 22'h010000,
	parameter logic [ADDR_W:0]   FLASH_WORDS = 23'h010000,
	parameter logic [ADDR_W-1:0] OTP_BASE    = 22'h008000
) (
	input wire logic          mclk,
	input wire logic          rst_n,
	input wire fopw_cpu_req_s cpu_req,
	input wire logic          cpu_stall,
	input wire logic          cpu_ack,
	input wire fopw_reg_req_s reg_req,
	input wire fopw_pwr_e     bank_pwr,
	input wire fopw_pwr_e     pump_pwr
);
	logic hit;
	assign hit = (cpu_req.addr >= FLASH_BASE && {1'b0, cpu_req.addr} < FLASH_BASE + FLASH_WORDS)
		|| (cpu_req.addr >= OTP_BASE && cpu_req.addr < OTP_BASE + 22'(OTP_WORDS));
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_take;
		cpu_req.valid && !cpu_stall && hit;
	endsequence
	sequence s_rd_low;
		s_take ##0 (!cpu_req.we && bank_pwr != FOPW_ACTIVE);
	endsequence
	property p_rst;
		$rose(rst_n) |-> bank_pwr == FOPW_SLEEP;
	endproperty
	property p_same;
		bank_pwr == pump_pwr;
	endproperty
	property p_low;
		reg_req.wr && reg_req.addr == REG_POWER && reg_req.wdata[1:0] == 2'h0
			|=> bank_pwr == FOPW_SLEEP;
	endproperty
	property p_wake;
		s_rd_low |=> cpu_stall;
	endproperty
	property p_hold;
		cpu_stall && bank_pwr != FOPW_ACTIVE |=> !cpu_ack;
	endproperty
	property p_step;
		$past(bank_pwr) == FOPW_SLEEP |-> bank_pwr != FOPW_ACTIVE;
	endproperty
	property p_wr;
		s_take ##0 cpu_req.we |=> cpu_ack && !cpu_stall;
	endproperty
	property p_end;
		$fell(cpu_stall) |-> cpu_ack;
	endproperty
	a_rst: assert property (p_rst) else $error("power not asleep after reset");
	a_same: assert property (p_same) else $error("bank and pump differ");
	a_low: assert property (p_low) else $error("lower power not immediate");
	a_wake: assert property (p_wake) else $error("no stall on wake");
	a_hold: assert property (p_hold) else $error("ack before active");
	a_step: assert property (p_step) else $error("sleep jumped to active");
	a_wr: assert property (p_wr) else $error("write not done in one cycle");
	a_end: assert property (p_end) else $error("stall ended without ack");
endmodule
bind fopw_core fopw_assertions #(
	.FLASH_BASE(FLASH_BASE),
	.FLASH_WORDS(FLASH_WORDS),
	.OTP_BASE(OTP_BASE)
) chk_u (
	.mclk(mclk),
	.rst_n(rst_n),
	.cpu_req(cpu_req),
	.cpu_stall(cpu_stall),
	.cpu_ack(cpu_ack),
	.reg_req(reg_req),
	.bank_pwr(bank_pwr),
	.pump_pwr(pump_pwr)
);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the flash and OTP power and wait control
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import fopw_pkg::*;
;
	localparam logic [21:0] FB = 22'h010000;
	localparam logic [21:0] OB = 22'h008000;
	logic          mclk;
	logic          rst_n;
	fopw_cpu_req_s cpu_req;
	fopw_reg_req_s reg_req;
	logic          cpu_stall;
	logic          cpu_ack;
	logic          mem_rd;
	logic [31:0]   cpu_rdata;
	logic [31:0]   mem_rdata;
	logic [15:0]   reg_rdata;
	logic [21:0]   mem_addr;
	fopw_pwr_e     bank_pwr;
	fopw_pwr_e     pump_pwr;
	int            err_count;
	int            n_checks;
	int            cyc;
	int            n;
	fopw_core dut_u (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_stall(cpu_stall),
		.cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.bank_pwr(bank_pwr), .pump_pwr(pump_pwr));
	fopw_mem_model mem_u (.rd(mem_rd), .addr(mem_addr), .data(mem_rdata));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 4000) begin
			err_count++;
			report_and_stop;
		end
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		reg_req <= '0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk);
		reg_req <= '0;
		#1;
		chk({16'h0000, reg_rdata}, {16'h0000, e});
	endtask
	task automatic acc(input logic w, input fopw_kind_e k, input logic [21:0] a);
		@(posedge mclk);
		cpu_req <= '{1'b1, w, k, a};
		@(posedge mclk);
		cpu_req <= '0;
		n = 1;
		#1;
		while (cpu_ack !== 1'b1 && n < 1200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (!w) chk(cpu_rdata, k[0] ? {16'h0000, a[15:0]} : {10'h3C5, a});
	endtask
	task automatic t_reset;
		chk({30'h0, bank_pwr}, {30'h0, FOPW_SLEEP});
		rd(REG_BANK, 16'h0F0F);
		rd(REG_STDBY, STDBY_RST);
		rd(REG_ACTIVE, ACTIVE_RST);
		rd(16'h0A90, 16'h0000);
		wr(REG_STDBY, STDBY_RST);
		wr(REG_ACTIVE, ACTIVE_RST);
		wr(REG_BANK, 16'h0002);
		wr(REG_OTP, 16'h0003);
	endtask
	task automatic t_wake;
		acc(1'b0, KIND_FETCH32, FB);
		chk(32'(n), 32'(3 + STDBY_RST + ACTIVE_RST + 2));
		chk({30'h0, bank_pwr}, {30'h0, FOPW_ACTIVE});
		chk({30'h0, pump_pwr}, {30'h0, FOPW_ACTIVE});
		rd(REG_POWER, 16'h0003);
		wr(REG_POWER, 16'h0001);
		#1;
		chk({30'h0, bank_pwr}, {30'h0, FOPW_STANDBY});
		rd(REG_STATUS, 16'h0001);
		acc(1'b0, KIND_DATA16, OB);
		chk(32'(n), 32'(3 + ACTIVE_RST + 3));
	endtask
	task automatic t_wait;
		acc(1'b0, KIND_DATA32, FB + 22'h100);
		chk(32'(n), 32'h3);
		acc(1'b0, KIND_DATA16, FB + 22'h17F);
		chk(32'(n), 32'h1);
		acc(1'b0, KIND_PROG16, FB + 22'h180);
		chk(32'(n), 32'h3);
		acc(1'b0, KIND_FETCH32, OB + 22'h3FF);
		chk(32'(n), 32'h4);
		acc(1'b0, KIND_DATA32, FB + 22'h181);
		chk(32'(n), 32'h1);
		acc(1'b1, KIND_DATA32, FB);
		chk(32'(n), 32'h1);
	endtask
	task automatic t_power;
		wr(REG_POWER, 16'h0000);
		#1;
		chk({30'h0, bank_pwr}, {30'h0, FOPW_SLEEP});
		wr(REG_POWER, 16'h0003);
		n = 0;
		while (bank_pwr !== FOPW_ACTIVE && n < 1100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(32'(n), 32'(1 + STDBY_RST + ACTIVE_RST));
	endtask
	initial begin
		err_count = 0;
		n_checks = 0;
		cyc = 0;
		rst_n = 1'b0;
		cpu_req = '0;
		reg_req = '0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		t_wake;
		t_wait;
		t_power;
		report_and_stop;
	end
endmodule
`default_nettype wire
